// *** inc/ffm_consts.svh ***
// Constants of the freefall/motion event detector: offsets, field
// positions, reset values and widths.
// Assumes inclusion by ffm_pkg and by the design files by bare name.
`ifndef FFM_CONSTS_SVH
`define FFM_CONSTS_SVH

// ----------------------------------------------------------------------
// Widths
// ----------------------------------------------------------------------
`define FFM_ADDR_W 8
`define FFM_DATA_W 8
`define FFM_SAMPLE_W 10
`define FFM_THS_W 7
`define FFM_CNT_W 8
`define FFM_IRQ_W 2

// ----------------------------------------------------------------------
// Register offsets
// ----------------------------------------------------------------------
`define FFM_OFS_CFG 8'h15
`define FFM_OFS_SRC 8'h16
`define FFM_OFS_THS 8'h17
`define FFM_OFS_CNT 8'h18
`define FFM_OFS_IRQ_STAT 8'h19
`define FFM_OFS_IRQ_CLR 8'h1A
`define FFM_OFS_IRQ_EN 8'h1B

// ----------------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------------
`define FFM_CFG_LATCH 7
`define FFM_CFG_COMBINE 6
`define FFM_CFG_Z_EN 5
`define FFM_CFG_X_EN 3
`define FFM_SRC_EA 7
`define FFM_THS_DBMODE 7
`define FFM_IRQ_RISE 0
`define FFM_IRQ_FALL 1

// ----------------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------------
`define FFM_RST_CFG 5'h00
`define FFM_RST_THS 7'h00
`define FFM_RST_CNT 8'h00
`define FFM_RST_IRQ 2'h0

`endif

// *** inc/ffm_pkg.sv ***
// Types shared by the freefall/motion event detector files.
// Assumes ffm_consts.svh is on the include path.
`include "ffm_consts.svh"

package ffm_pkg;

  // Three axis sample, weight equal to one threshold count
  typedef struct packed {
    logic signed [`FFM_SAMPLE_W-1:0] z;
    logic signed [`FFM_SAMPLE_W-1:0] y;
    logic signed [`FFM_SAMPLE_W-1:0] x;
  } ffm_accel_s;

  // One register bus request
  typedef struct packed {
    logic [`FFM_ADDR_W-1:0] addr;
    logic [`FFM_DATA_W-1:0] wdata;
    logic wr;
    logic rd;
  } ffm_bus_req_s;

  // Combining of the enabled axes
  typedef enum logic {
    FFM_FREEFALL,
    FFM_MOTION
  } ffm_combine_e;

endpackage

// *** design/ffm_axis_cmp.sv ***
// Per-axis magnitude comparator of the freefall/motion detector.
// Assumes the sample and the threshold share one count weight.
`timescale 1ns/1ps
`include "ffm_consts.svh"

module ffm_axis_cmp
  import ffm_pkg::*;
#(
  parameter int SAMPLE_W = `FFM_SAMPLE_W
)
(
  input wire logic signed [SAMPLE_W-1:0] i_sample,
  input wire logic [`FFM_THS_W-1:0] i_threshold,
  output logic o_above,
  output logic o_negative
);

  // ----------------------------------------------------------------------
  // Magnitude and compare
  // ----------------------------------------------------------------------
  logic [SAMPLE_W-1:0] magnitude;
  logic [SAMPLE_W-1:0] ths_wide;

  // Most negative code still fits as unsigned magnitude
  assign magnitude = i_sample[SAMPLE_W-1] ? SAMPLE_W'(-i_sample) : SAMPLE_W'(i_sample);
  assign ths_wide = SAMPLE_W'(i_threshold);
  // Strictly above is a high-g hit; at or below counts as low g
  assign o_above = (magnitude > ths_wide); // [RULE_14] [RULE_17]
  assign o_negative = i_sample[SAMPLE_W-1]; // [RULE_16]

endmodule

// *** design/ffm_detector.sv ***
// Freefall/motion event detector with register port and interrupt.
// Assumes samples and the sample tick come from logic on i_clk_sys,
// and a bus master that never issues read and write together.
//
// Functional notes
// RULE_01 - Combine-select 0 runs freefall detection, 1 runs motion detection.
// RULE_02 - All three axis enables cleared disables the detector, no event.
// RULE_03 - Latch-enable and combine-select together pick one of four modes.
// RULE_04 - Event-active sets only once the debounce counter completes.
// RULE_05 - Only enabled axes take part in the combined condition.
// RULE_06 - Live, debounce mode 0: event-active clears after the count decays.
// RULE_07 - Live, debounce mode 1: clears at once, re-arms after full delay.
// RULE_08 - Live modes: reading the source register has no side effect.
// RULE_09 - Axis flags follow raw comparison when live or event inactive.
// RULE_10 - Latched: event-active holds until source read; read clears counter.
// RULE_11 - Latched: axis flags freeze on event, resume after source read.
// RULE_12 - Latched motion: source read clears all source bits and counter.
// RULE_13 - Config holds latch, combine, Z/Y/X enables in 7..3; 2..0 zero.
// RULE_14 - Motion hit above threshold; freefall needs all enabled at or below.
// RULE_15 - Debounce mode 0 decrements on miss, mode 1 clears the counter.
// RULE_16 - Polarity flag 0 for positive, 1 for negative acceleration.
// RULE_17 - Seven bit unsigned threshold, one count per threshold weight.
// RULE_18 - Counter moves once per sample tick; event when count reached.
// RULE_19 - Configuration, flags and counter reset to zero.
`timescale 1ns/1ps
`include "ffm_consts.svh"

module ffm_detector
  import ffm_pkg::*;
(
  input wire logic i_clk_sys,
  input wire logic i_rst_n,
  input wire ffm_bus_req_s i_bus,
  output logic [`FFM_DATA_W-1:0] o_rd_data,
  input wire logic i_sample_tick,
  input wire ffm_accel_s i_accel,
  output logic o_event_active,
  output logic o_irq
);

  // ----------------------------------------------------------------------
  // Register state
  // ----------------------------------------------------------------------
  logic [4:0] cfg_bits;
  logic debounce_mode;
  logic [`FFM_THS_W-1:0] threshold;
  logic [`FFM_CNT_W-1:0] delay_count;
  logic event_active;
  logic [`FFM_CNT_W-1:0] db_cnt;
  logic [2:0] hit_flag;
  logic [2:0] pol_flag;
  logic [`FFM_IRQ_W-1:0] irq_status;
  logic [`FFM_IRQ_W-1:0] irq_enable;
  logic [`FFM_DATA_W-1:0] rd_data;

  logic next_event_active;
  logic [`FFM_CNT_W-1:0] next_db_cnt;
  logic [2:0] next_hit_flag;
  logic [2:0] next_pol_flag;
  logic [`FFM_IRQ_W-1:0] next_irq_status;

  // ----------------------------------------------------------------------
  // Configuration fields
  // ----------------------------------------------------------------------
  wire latch_en = cfg_bits[4];
  wire ffm_combine_e combine_select = ffm_combine_e'(cfg_bits[3]); // [RULE_01] [RULE_03]
  wire [2:0] axis_en = cfg_bits[2:0];
  wire detector_off = (axis_en == 3'h0);

  // ----------------------------------------------------------------------
  // Address decode
  // ----------------------------------------------------------------------
  wire wr_cfg = i_bus.wr && (i_bus.addr == `FFM_OFS_CFG);
  wire wr_ths = i_bus.wr && (i_bus.addr == `FFM_OFS_THS);
  wire wr_cnt = i_bus.wr && (i_bus.addr == `FFM_OFS_CNT);
  wire wr_irq_clr = i_bus.wr && (i_bus.addr == `FFM_OFS_IRQ_CLR);
  wire wr_irq_en = i_bus.wr && (i_bus.addr == `FFM_OFS_IRQ_EN);
  wire src_read = i_bus.rd && (i_bus.addr == `FFM_OFS_SRC);
  // Only latched modes give the source read a side effect
  wire latched_read = src_read && latch_en; // [RULE_08]

  // ----------------------------------------------------------------------
  // Per-axis comparison
  // ----------------------------------------------------------------------
  logic signed [`FFM_SAMPLE_W-1:0] axis_sample [3];
  logic [2:0] axis_above;
  logic [2:0] axis_negative;

  // Index 2 is Z, 1 is Y, 0 is X, matching the enable bits
  assign axis_sample[2] = i_accel.z;
  assign axis_sample[1] = i_accel.y;
  assign axis_sample[0] = i_accel.x;

  genvar g_axis;
  generate
    for (g_axis = 0; g_axis < 3; g_axis++)
    begin : g_cmp
      ffm_axis_cmp #(
        .SAMPLE_W(`FFM_SAMPLE_W)
      ) u_cmp (
        .i_sample(axis_sample[g_axis]),
        .i_threshold(threshold),
        .o_above(axis_above[g_axis]),
        .o_negative(axis_negative[g_axis])
      );
    end
  endgenerate

  // ----------------------------------------------------------------------
  // Combined condition
  // ----------------------------------------------------------------------
  wire [2:0] en_above = axis_above & axis_en; // [RULE_05]
  wire motion_cond = |en_above; // [RULE_14]
  // An axis that is off cannot veto freefall
  wire freefall_cond = !detector_off && (en_above == 3'h0); // [RULE_14]
  wire cond = (combine_select == FFM_MOTION) ? motion_cond : freefall_cond; // [RULE_01]

  // ----------------------------------------------------------------------
  // Debounce arithmetic
  // ----------------------------------------------------------------------
  // Counter saturates at the programmed count, so no wrap can occur
  wire cnt_at_limit = (db_cnt >= delay_count);
  wire [`FFM_CNT_W-1:0] cnt_step = cnt_at_limit ? db_cnt : db_cnt + `FFM_CNT_W'(1);
  wire [`FFM_CNT_W-1:0] cnt_dec = (db_cnt == '0) ? db_cnt : db_cnt - `FFM_CNT_W'(1);
  wire cnt_reached = (cnt_step >= delay_count); // [RULE_18]
  // A latched event stops the counter and the flags until read
  wire frozen = latch_en && event_active; // [RULE_11]
  wire advance = i_sample_tick && !frozen; // [RULE_18]

  // ----------------------------------------------------------------------
  // Event-active and counter next state
  // ----------------------------------------------------------------------
  always_comb
  begin
    next_db_cnt = db_cnt;
    next_event_active = event_active;
    if (latched_read)
    begin
      // Read wins over a same-cycle tick: a new event needs the full delay
      next_db_cnt = '0; // [RULE_10] [RULE_12]
      next_event_active = 1'b0; // [RULE_10]
    end
    else if (detector_off)
    begin
      next_db_cnt = '0; // [RULE_02]
      next_event_active = 1'b0; // [RULE_02]
    end
    else if (advance)
    begin
      if (cond)
      begin
        next_db_cnt = cnt_step; // [RULE_18]
        if (cnt_reached)
        begin
          next_event_active = 1'b1; // [RULE_04]
        end
      end
      else if (debounce_mode)
      begin
        next_db_cnt = '0; // [RULE_15] [RULE_07]
        if (!latch_en)
        begin
          next_event_active = 1'b0; // [RULE_07]
        end
      end
      else
      begin
        next_db_cnt = cnt_dec; // [RULE_15]
        if (!latch_en && (cnt_dec == '0))
        begin
          next_event_active = 1'b0; // [RULE_06]
        end
      end
    end
  end

  // ----------------------------------------------------------------------
  // Axis flags next state
  // ----------------------------------------------------------------------
  always_comb
  begin
    next_hit_flag = hit_flag;
    next_pol_flag = pol_flag;
    if (latched_read)
    begin
      next_hit_flag = 3'h0; // [RULE_12] [RULE_11]
      next_pol_flag = 3'h0; // [RULE_12]
    end
    else if (advance)
    begin
      // Undebounced, masked so a disabled axis reads zero
      next_hit_flag = axis_above & axis_en; // [RULE_09]
      next_pol_flag = axis_negative & axis_en; // [RULE_09] [RULE_16]
    end
  end

  // ----------------------------------------------------------------------
  // Interrupt status
  // ----------------------------------------------------------------------
  wire ev_rise = next_event_active && !event_active;
  wire ev_fall = !next_event_active && event_active;
  wire [`FFM_IRQ_W-1:0] irq_events = {ev_fall, ev_rise};
  wire [`FFM_IRQ_W-1:0] irq_clr_mask = wr_irq_clr ? i_bus.wdata[`FFM_IRQ_W-1:0] : '0;
  // New events win over a clear in the same cycle
  assign next_irq_status = (irq_status & ~irq_clr_mask) | irq_events;

  // ----------------------------------------------------------------------
  // Read mux
  // ----------------------------------------------------------------------
  wire [`FFM_DATA_W-1:0] cfg_value = {cfg_bits, 3'h0}; // [RULE_13]
  wire [`FFM_DATA_W-1:0] src_value = {event_active, 1'b0, hit_flag[2], pol_flag[2],
                                      hit_flag[1], pol_flag[1], hit_flag[0], pol_flag[0]};
  wire [`FFM_DATA_W-1:0] ths_value = {debounce_mode, threshold};
  wire [`FFM_DATA_W-1:0] stat_value = `FFM_DATA_W'(irq_status);
  wire [`FFM_DATA_W-1:0] en_value = `FFM_DATA_W'(irq_enable);
  // Unmapped offsets and the write-only clear read as zero
  wire [`FFM_DATA_W-1:0] rd_mux =
    (i_bus.addr == `FFM_OFS_CFG) ? cfg_value :
    (i_bus.addr == `FFM_OFS_SRC) ? src_value :
    (i_bus.addr == `FFM_OFS_THS) ? ths_value :
    (i_bus.addr == `FFM_OFS_CNT) ? delay_count :
    (i_bus.addr == `FFM_OFS_IRQ_STAT) ? stat_value :
    (i_bus.addr == `FFM_OFS_IRQ_EN) ? en_value : '0;

  // ----------------------------------------------------------------------
  // Software registers
  // ----------------------------------------------------------------------
  always_ff @(posedge i_clk_sys or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      cfg_bits <= `FFM_RST_CFG; // [RULE_19]
      debounce_mode <= 1'b0;
      threshold <= `FFM_RST_THS;
      delay_count <= `FFM_RST_CNT;
      irq_enable <= `FFM_RST_IRQ;
    end
    else
    begin
      if (wr_cfg)
        cfg_bits <= i_bus.wdata[`FFM_CFG_LATCH:`FFM_CFG_X_EN]; // [RULE_13]
      if (wr_ths)
        {debounce_mode, threshold} <= i_bus.wdata; // [RULE_17]
      if (wr_cnt)
        delay_count <= i_bus.wdata;
      if (wr_irq_en)
        irq_enable <= i_bus.wdata[`FFM_IRQ_W-1:0];
    end
  end

  // ----------------------------------------------------------------------
  // Detector state
  // ----------------------------------------------------------------------
  always_ff @(posedge i_clk_sys or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      event_active <= 1'b0; // [RULE_19]
      db_cnt <= '0;
      hit_flag <= 3'h0;
      pol_flag <= 3'h0;
      irq_status <= `FFM_RST_IRQ;
    end
    else
    begin
      event_active <= next_event_active;
      db_cnt <= next_db_cnt;
      hit_flag <= next_hit_flag;
      pol_flag <= next_pol_flag;
      irq_status <= next_irq_status;
    end
  end

  // ----------------------------------------------------------------------
  // Read data, valid only in the cycle after the read strobe
  // ----------------------------------------------------------------------
  always_ff @(posedge i_clk_sys or negedge i_rst_n)
  begin
    if (!i_rst_n)
      rd_data <= '0;
    else
      rd_data <= i_bus.rd ? rd_mux : '0;
  end

  assign o_rd_data = rd_data;
  assign o_event_active = event_active;
  assign o_irq = |(irq_status & irq_enable);

  // ----------------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------------
  default clocking cb_sys @(posedge i_clk_sys);
  endclocking
  default disable iff (!i_rst_n);

  AST_CFG_LOW_ZERO: assert property ( // [RULE_13]
    (i_bus.rd && i_bus.addr == `FFM_OFS_CFG) |=> (o_rd_data[2:0] == 3'h0))
    else $error("config low bits not zero");

  AST_OFF_NO_EVENT: assert property ( // [RULE_02]
    detector_off |=> !event_active)
    else $error("event active while all axes disabled");

  AST_EA_AFTER_COUNT: assert property ( // [RULE_04]
    $rose(event_active) |-> $past(i_sample_tick) && $past(cond)
                            && ($past(db_cnt) + 9'h001 >= {1'b0, $past(delay_count)}))
    else $error("event active set before debounce completed");

  AST_LIVE_READ_CLEAN: assert property ( // [RULE_08]
    (!latch_en && src_read && !i_sample_tick && !detector_off)
    |=> ($stable(event_active) && $stable(db_cnt) && $stable(hit_flag)))
    else $error("live source read changed state");

  AST_LATCH_HOLD: assert property ( // [RULE_10]
    (latch_en && event_active && !src_read && !detector_off) |=> event_active)
    else $error("latched event dropped without read");

  AST_LATCH_READ_CLR: assert property ( // [RULE_10]
    (latch_en && src_read) |=> (!event_active && db_cnt == '0))
    else $error("latched read did not clear event and counter");

  AST_MOTION_READ_ALL: assert property ( // [RULE_12]
    (latch_en && combine_select == FFM_MOTION && src_read)
    |=> (!event_active && hit_flag == 3'h0 && pol_flag == 3'h0 && db_cnt == '0))
    else $error("latched motion read left source bits set");

  AST_FLAGS_FROZEN: assert property ( // [RULE_11]
    (latch_en && event_active && !src_read) |=> ($stable(hit_flag) && $stable(pol_flag)))
    else $error("flags moved while latched");

  AST_MODE1_MISS: assert property ( // [RULE_07]
    (!latch_en && debounce_mode && i_sample_tick && !cond) |=> (!event_active && db_cnt == '0))
    else $error("debounce mode 1 miss did not clear");

  AST_MODE0_DECAY: assert property ( // [RULE_06]
    (!latch_en && !debounce_mode && event_active && i_sample_tick && !cond
     && !detector_off && db_cnt > 8'h01) |=> (event_active && db_cnt == $past(db_cnt) - 8'h01))
    else $error("debounce mode 0 did not decay");

  AST_DISABLED_AXIS_ZERO: assert property ( // [RULE_09]
    (advance && !latched_read) |=> ((hit_flag & ~$past(axis_en)) == 3'h0
                                    && (pol_flag & ~$past(axis_en)) == 3'h0))
    else $error("disabled axis flag set");

  CVR_LATCHED_EVENT: cover property (latch_en && $rose(event_active));
  CVR_MODE0_CLEAR: cover property (!latch_en && !debounce_mode && $fell(event_active));
  CVR_FREEFALL_LIVE: cover property (!latch_en && combine_select == FFM_FREEFALL
                                     && $rose(event_active));
  CVR_IRQ: cover property ($rose(o_irq));

endmodule

// *** sim/ffm_host_model.sv ***
// Host processor model: register writes and reads on the plain port.
// Assumes a slave that samples on the rising edge and never waits.
`timescale 1ns/1ps

module ffm_host_model
  import ffm_pkg::*;
(
  input wire logic i_clk_sys,
  input wire logic [7:0] i_rd_data,
  output ffm_bus_req_s o_bus
);
  // ----------------------------------------------------------------
  // Bus cycles
  // ----------------------------------------------------------------
  // Released lines carry the inverse of the last value, so stale
  // address or data can never pass for a live request
  initial o_bus = '0;

  // One-cycle write strobe beside address and data
  task automatic bus_write(input logic [7:0] addr, input logic [7:0] data);
    @(posedge i_clk_sys);
    o_bus <= '{addr: addr, wdata: data, wr: 1'b1, rd: 1'b0};
    @(posedge i_clk_sys);
    o_bus <= '{addr: ~addr, wdata: ~data, wr: 1'b0, rd: 1'b0};
  endtask

  // Read data stand only in the cycle after the strobe
  task automatic bus_read(input logic [7:0] addr, output logic [7:0] data);
    @(posedge i_clk_sys);
    o_bus <= '{addr: addr, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
    @(posedge i_clk_sys);
    o_bus <= '{addr: ~addr, wdata: 8'hFF, wr: 1'b0, rd: 1'b0};
    #1;
    data = i_rd_data;
  endtask
endmodule

// *** sim/test_ffm_detector.sv ***
// Self-checking bench of the freefall/motion event detector.
// Assumes the host model drives the register port; samples come from here.
`timescale 1ns/1ps

module test_ffm_detector
  import ffm_pkg::*;
;
  logic i_clk_sys;
  logic i_rst_n;
  logic i_sample_tick;
  ffm_accel_s i_accel;
  ffm_bus_req_s bus;
  logic [7:0] o_rd_data;
  logic o_event_active;
  logic o_irq;
  int fail_count;
  int comparisons;

  // ----------------------------------------------------------------
  // Clock, design and host
  // ----------------------------------------------------------------
  // 10 MHz system clock
  initial
  begin
    i_clk_sys = 1'b0;
    forever #50 i_clk_sys = ~i_clk_sys;
  end

  ffm_detector i_ffm_detector (
    .i_clk_sys(i_clk_sys),
    .i_rst_n(i_rst_n),
    .i_bus(bus),
    .o_rd_data(o_rd_data),
    .i_sample_tick(i_sample_tick),
    .i_accel(i_accel),
    .o_event_active(o_event_active),
    .o_irq(o_irq)
  );

  ffm_host_model i_ffm_host_model (
    .i_clk_sys(i_clk_sys),
    .i_rd_data(o_rd_data),
    .o_bus(bus)
  );

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  task automatic end_of_test();
    $display("Comparisons %0d, mismatches %0d", comparisons, fail_count);
    if (fail_count == 0 && comparisons > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask

  task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string what);
    comparisons++;
    if (got !== exp)
    begin
      $display("Error at %0t: %s got %h expected %h", $time, what, got, exp);
      fail_count++;
    end
  endtask

  task automatic wr(input logic [7:0] addr, input logic [7:0] data);
    i_ffm_host_model.bus_write(addr, data);
  endtask

  task automatic rd(input logic [7:0] addr, input logic [7:0] exp);
    logic [7:0] d;
    i_ffm_host_model.bus_read(addr, d);
    chk(d, exp, "register read");
  endtask

  // Level outputs looked at once the write or tick edge has landed
  task automatic pins(input logic ea, input logic irq);
    #1;
    chk({7'h00, o_event_active}, {7'h00, ea}, "event active pin");
    chk({7'h00, o_irq}, {7'h00, irq}, "interrupt pin");
  endtask

  // One sample with its one-cycle tick
  task automatic tick(input logic [9:0] z, input logic [9:0] y, input logic [9:0] x);
    @(posedge i_clk_sys);
    i_sample_tick <= 1'b1;
    i_accel <= '{z: z, y: y, x: x};
    @(posedge i_clk_sys);
    i_sample_tick <= 1'b0;
    i_accel <= '{z: ~z, y: ~y, x: ~x};
  endtask

  // Hang guard: far above the length of the main sequence
  initial
  begin
    repeat (20000) @(posedge i_clk_sys);
    $display("Error at %0t: run did not finish", $time);
    fail_count++;
    end_of_test();
  end

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial
  begin
    fail_count = 0;
    comparisons = 0;
    i_rst_n = 1'b0;
    i_sample_tick = 1'b0;
    i_accel = '0;
    repeat (4) @(posedge i_clk_sys);
    i_rst_n <= 1'b1;
    // Reset values and config layout
    rd(8'h15, 8'h00);
    rd(8'h16, 8'h00);
    rd(8'h17, 8'h00);
    rd(8'h18, 8'h00);
    rd(8'h1B, 8'h00);
    wr(8'h15, 8'hFF);
    rd(8'h15, 8'hF8);
    rd(8'h40, 8'h00);
    // Live motion, X only, threshold 10, delay 2, decrement mode
    wr(8'h15, 8'h48);
    wr(8'h17, 8'h0A);
    wr(8'h18, 8'h02);
    tick(10'd0, 10'd0, 10'd11);
    pins(1'b0, 1'b0);
    rd(8'h16, 8'h02);
    tick(10'd0, 10'd0, -10'sd11);
    pins(1'b1, 1'b0);
    rd(8'h16, 8'h83);
    rd(8'h16, 8'h83);
    rd(8'h19, 8'h01);
    wr(8'h1B, 8'h01);
    pins(1'b1, 1'b1);
    wr(8'h1A, 8'h01);
    pins(1'b1, 1'b0);
    // Equal to threshold is no hit; Y disabled so ignored
    tick(10'd0, 10'd100, 10'd10);
    pins(1'b1, 1'b0);
    rd(8'h16, 8'h80);
    tick(10'd0, 10'd100, 10'd10);
    pins(1'b0, 1'b0);
    rd(8'h19, 8'h02);
    wr(8'h1B, 8'h03);
    pins(1'b0, 1'b1);
    wr(8'h1A, 8'h02);
    pins(1'b0, 1'b0);
    wr(8'h1B, 8'h00);
    // Clear mode: drops at once, then needs the full delay again
    wr(8'h17, 8'h8A);
    tick(10'd0, 10'd0, 10'd50);
    tick(10'd0, 10'd0, 10'd50);
    pins(1'b1, 1'b0);
    tick(10'd0, 10'd0, 10'd3);
    pins(1'b0, 1'b0);
    tick(10'd0, 10'd0, 10'd50);
    pins(1'b0, 1'b0);
    tick(10'd0, 10'd0, 10'd50);
    pins(1'b1, 1'b0);
    // No axis enabled: detector dead
    wr(8'h15, 8'h40);
    tick(10'd100, 10'd100, 10'd100);
    tick(10'd100, 10'd100, 10'd100);
    pins(1'b0, 1'b0);
    rd(8'h16, 8'h00);
    // Latched motion: flags frozen, read clears, fresh delay
    wr(8'h17, 8'h0A);
    wr(8'h15, 8'hC8);
    tick(10'd0, 10'd0, -10'sd11);
    tick(10'd0, 10'd0, -10'sd11);
    tick(10'd0, 10'd0, 10'd5);
    pins(1'b1, 1'b0);
    rd(8'h16, 8'h83);
    rd(8'h16, 8'h00);
    pins(1'b0, 1'b0);
    tick(10'd0, 10'd0, 10'd20);
    pins(1'b0, 1'b0);
    rd(8'h16, 8'h02);
    // Live freefall, all axes, delay 1
    wr(8'h15, 8'h00);
    tick(10'd0, 10'd0, 10'd0);
    wr(8'h18, 8'h01);
    wr(8'h15, 8'h38);
    tick(10'd5, -10'sd5, 10'd10);
    pins(1'b1, 1'b0);
    rd(8'h16, 8'h84);
    tick(-10'sd20, 10'd0, 10'd0);
    pins(1'b0, 1'b0);
    rd(8'h16, 8'h30);
    // Latched freefall
    wr(8'h15, 8'hB8);
    tick(10'd0, 10'd0, 10'd0);
    pins(1'b1, 1'b0);
    rd(8'h16, 8'h80);
    rd(8'h16, 8'h00);
    end_of_test();
  end
endmodule
